// >>> common/dac_pkg.sv
// Constants and types shared by the converter control ends.
// Functional notes
// - Mode 00 idles both, 01 idles Q.
// - Mode 10 in phase, 11 Q shifted.
// - Delayed mode holds Q half period.
// - Mode pins are asynchronous to clocks.
// - Standby channel holds its last word.
// - Twenty cycles invalid after standby exit.
// - Twenty cycles invalid after power up.
// - Clock source must exceed one MSPS.
// - Clock duty cycle fifty percent, five.
// - Delayed mode realigns inverted clock channels.
// - Word appears six cycles after sample; the code takes seven.
// - Output word is offset binary coded.
package dac_pkg;
  localparam int unsigned DAC_DATA_W     = 10;
  localparam int unsigned DAC_LATENCY    = 6;
  localparam int unsigned DAC_RECOVER    = 20;
  localparam int unsigned DAC_FIFO_DEPTH = 8;
  localparam int unsigned DAC_CNT_W      = 5;
  localparam logic [DAC_CNT_W-1:0] DAC_RECOVER_CNT = 5'h14;
  localparam logic [DAC_DATA_W-1:0] DAC_MID_CODE  = 10'h200;

  typedef logic [DAC_DATA_W-1:0] dac_word_t;

  typedef enum logic [1:0] {
    DAC_MODE_ALL_IDLE = 2'h0,
    DAC_MODE_Q_IDLE   = 2'h1,
    DAC_MODE_PHASE    = 2'h2,
    DAC_MODE_DELAY    = 2'h3
  } dac_mode_t;

  typedef enum logic [2:0] {
    DAC_ST_IDLE  = 3'h1,
    DAC_ST_WARM  = 3'h2,
    DAC_ST_VALID = 3'h4
  } dac_state_t;

  // Two's complement sample to offset binary by flipping the sign bit.
  function automatic dac_word_t dac_offset_bin(input dac_word_t s);
    dac_offset_bin = {~s[DAC_DATA_W-1], s[DAC_DATA_W-2:0]};
  endfunction : dac_offset_bin
endpackage : dac_pkg

// >>> common/dac_link_if.sv
// Parallel data link between converter end and capturing end.
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
  import dac_pkg::*;
  dac_word_t i_data;
  dac_word_t q_data;
  logic      i_valid;
  logic      q_valid;
  modport conv (output i_data, output q_data, output i_valid,
                output q_valid);
  modport cap  (input i_data, input q_data, input i_valid,
                input q_valid);
endinterface : dac_link_if
`default_nettype wire

// >>> hdl/dac_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module dac_fifo
  import dac_pkg::*;
#(
  parameter int unsigned WIDTH = 2 * DAC_DATA_W,
  parameter int unsigned DEPTH = DAC_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = wr_valid_in & wr_ready_out & ce_in;
  wire              pop  = rd_valid_out & rd_ready_in & ce_in;

  assign wr_ready_out = (cnt_q < (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out  = mem_q[rp_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dac_fifo
`default_nettype wire

// >>> hdl/dac_conv_end.sv
// Converter end: mode pins, latency pipe, standby hold and warm-up.
`timescale 1ns/1ps
`default_nettype none
module dac_conv_end
  import dac_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      ce_in,
  input  wire logic      mode_select_first_in,
  input  wire logic      mode_select_second_in,
  input  wire dac_word_t i_sample_in,
  input  wire dac_word_t q_sample_in,
  output logic           i_running_out,
  output logic           q_running_out,
  dac_link_if.conv       link
);
  // ------------------------------------------------------------
  // Mode pin synchronisers
  // ------------------------------------------------------------
  // Three stage sync.
  logic [2:0] msf_sync_q;
  logic [2:0] mss_sync_q;
  logic [1:0] mode_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msf_sync_q <= '0;
      mss_sync_q <= '0;
      mode_q     <= DAC_MODE_ALL_IDLE;
    end else if (ce_in) begin
      msf_sync_q <= {msf_sync_q[1:0], mode_select_first_in};
      mss_sync_q <= {mss_sync_q[1:0], mode_select_second_in};
      // A change is accepted only when stages two and three agree.
      if (msf_sync_q[2] == msf_sync_q[1]) mode_q[1] <= msf_sync_q[2];
      if (mss_sync_q[2] == mss_sync_q[1]) mode_q[0] <= mss_sync_q[2];
    end
  end

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // Channel run decode.
  wire i_run   = (mode_q != DAC_MODE_ALL_IDLE);
  wire q_run   = mode_q[1];
  wire q_delay = (mode_q == DAC_MODE_DELAY);

  // ------------------------------------------------------------
  // Latency pipeline
  // ------------------------------------------------------------
  dac_word_t i_pipe_q [DAC_LATENCY];
  dac_word_t q_pipe_q [DAC_LATENCY];
  genvar g;
  generate
    for (g = 0; g < DAC_LATENCY; g++) begin : g_pipe
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          i_pipe_q[g] <= DAC_MID_CODE;
          q_pipe_q[g] <= DAC_MID_CODE;
        end else if (ce_in) begin
          if (i_run) i_pipe_q[g] <= (g == 0) ?
            dac_offset_bin(i_sample_in) : i_pipe_q[g-((g>0)?1:0)];
          if (q_run) q_pipe_q[g] <= (g == 0) ?
            dac_offset_bin(q_sample_in) : q_pipe_q[g-((g>0)?1:0)];
        end
      end
    end
  endgenerate
  wire dac_word_t i_tail = i_pipe_q[DAC_LATENCY-1];
  wire dac_word_t q_tail = q_pipe_q[DAC_LATENCY-1];

  // ------------------------------------------------------------
  // Half period delay of the Q word
  // ------------------------------------------------------------
  // Falling edge retime.
  // This is the only negedge flop; it gives the half period shift and
  // lets a Q end on an inverted clock line up with the I word.
  dac_word_t q_out_q;
  dac_word_t q_half_q;
  always_ff @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) q_half_q <= DAC_MID_CODE;
    else if (ce_in && q_run) q_half_q <= q_out_q;
  end

  // ------------------------------------------------------------
  // Warm-up counters
  // ------------------------------------------------------------
  // Twenty cycle invalid window.
  logic [DAC_CNT_W-1:0] i_cnt_q;
  logic [DAC_CNT_W-1:0] q_cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      i_cnt_q <= '0;
      q_cnt_q <= '0;
    end else if (ce_in) begin
      if (!i_run) i_cnt_q <= '0;
      else if (i_cnt_q != DAC_RECOVER_CNT) i_cnt_q <= i_cnt_q + 1'b1;
      if (!q_run) q_cnt_q <= '0;
      else if (q_cnt_q != DAC_RECOVER_CNT) q_cnt_q <= q_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.i_data  <= DAC_MID_CODE;
      q_out_q      <= DAC_MID_CODE;
      link.i_valid <= 1'b0;
      link.q_valid <= 1'b0;
    end else if (ce_in) begin
      if (i_run) link.i_data <= i_tail;
      if (q_run) q_out_q <= q_tail;
      link.i_valid <= i_run & (i_cnt_q == DAC_RECOVER_CNT);
      link.q_valid <= q_run & (q_cnt_q == DAC_RECOVER_CNT);
    end
  end

  // Delayed Q word leaves on the falling edge.
  assign link.q_data   = q_delay ? q_half_q : q_out_q;
  assign i_running_out = i_run;
  assign q_running_out = q_run;
endmodule : dac_conv_end
`default_nettype wire

// >>> hdl/dac_cap_end.sv
// Capturing end: keeps only valid words (valid pairs when need_q_in is set) and buffers them.
`timescale 1ns/1ps
`default_nettype none
module dac_cap_end
  import dac_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      ce_in,
  dac_link_if.cap        link,
  input  wire logic      need_q_in,
  output dac_word_t      i_word_out,
  output dac_word_t      q_word_out,
  output logic           word_valid_out,
  input  wire logic      word_ready_in,
  output logic           overflow_out
);
  wire take = link.i_valid & (link.q_valid | ~need_q_in);
  wire      fifo_ready;
  wire [2*DAC_DATA_W-1:0] rd_word;

  dac_fifo #(
    .WIDTH (2 * DAC_DATA_W),
    .DEPTH (DAC_FIFO_DEPTH)
  ) dac_fifo_i (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .wr_data_in   ({link.i_data, link.q_data}),
    .wr_valid_in  (take),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (rd_word),
    .rd_valid_out (word_valid_out),
    .rd_ready_in  (word_ready_in)
  );

  assign i_word_out = rd_word[2*DAC_DATA_W-1:DAC_DATA_W];
  assign q_word_out = rd_word[DAC_DATA_W-1:0];

  // The converter cannot be stalled, so a full buffer drops words; this
  // sticky flag tells the user that samples were lost.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) overflow_out <= 1'b0;
    else if (ce_in && take && !fifo_ready) overflow_out <= 1'b1;
  end
endmodule : dac_cap_end
`default_nettype wire

// >>> tb/dac_link_monitor.sv
// Checker watching the link between the two converter control ends.
`timescale 1ns/1ps
`default_nettype none
module dac_link_monitor
  import dac_pkg::*;
(
  input wire logic      clk_in,
  input wire logic      rst_n_in,
  input wire dac_word_t i_data,
  input wire dac_word_t q_data,
  input wire logic      i_valid,
  input wire logic      q_valid
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_i_warm_gap: assert property (
    $rose(i_valid) |-> !$past(i_valid, 20)) else $error("I warm short");
  a_q_warm_gap: assert property (
    $rose(q_valid) |-> !$past(q_valid, 20)) else $error("Q warm short");
  a_q_needs_i: assert property (
    q_valid |-> i_valid) else $error("Q runs without I");
  a_pair_fall: assert property (
    $fell(i_valid) |-> !q_valid) else $error("Q left running");
  a_i_hold_word: assert property (
    $fell(i_valid) |=> $stable(i_data)[*3]) else $error("I word moved");
  a_q_hold_word: assert property (
    $fell(q_valid) |=> $stable(q_data)[*3]) else $error("Q word moved");
  a_boot_quiet: assert property (
    $rose(rst_n_in) |-> (!i_valid && !q_valid)[*8])
    else $error("valid too early");
  a_boot_mid: assert property (
    $rose(rst_n_in) |-> (i_data == DAC_MID_CODE && q_data == DAC_MID_CODE)[*3])
    else $error("reset word lost");
  c_q_start: cover property ($rose(q_valid));
  c_q_idle: cover property ($fell(q_valid) && i_valid);
  c_all_idle: cover property ($fell(i_valid));
endmodule : dac_link_monitor
`default_nettype wire

// >>> tb/dac_tb_top.sv
// Bench joining converter and capturing ends across the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module dac_tb_top;
  import dac_pkg::*;
  logic       clk_in   = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [1:0] mode     = 2'h0;
  dac_word_t  i_smp    = 10'h000;
  dac_word_t  q_smp    = 10'h000;
  dac_word_t  iw, qw;
  logic       irun, qrun, wv, ovf;
  logic       wr       = 1'b0;
  int         n_errors = 0;
  int         checked  = 0;
  int         k, n;
  dac_link_if link ();
  dac_conv_end dac_conv_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .mode_select_first_in(mode[1]),
    .mode_select_second_in(mode[0]), .i_sample_in(i_smp),
    .q_sample_in(q_smp), .i_running_out(irun), .q_running_out(qrun),
    .link(link.conv));
  dac_cap_end dac_cap_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .link(link.cap), .need_q_in(1'b1), .i_word_out(iw),
    .q_word_out(qw), .word_valid_out(wv), .word_ready_in(wr),
    .overflow_out(ovf));
  dac_link_monitor dac_link_monitor_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .i_data(link.i_data), .q_data(link.q_data),
    .i_valid(link.i_valid), .q_valid(link.q_valid));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic print_verdict();
    $display("Compares %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic drive(input logic [1:0] m, input dac_word_t i, q);
    @(posedge clk_in);
    mode  <= m;
    i_smp <= i;
    q_smp <= q;
  endtask : drive
  // Bounded wait for Q valid; k returns cycles taken.
  task automatic wait_q();
    for (k = 0; k < 60 && link.q_valid !== 1'b1; k++) tick(1);
    if (k == 60) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_q
  task automatic t_boot();
    tick(30);
    `CHK(irun, 1'b0)
    `CHK(link.i_valid, 1'b0)
    `CHK(link.i_data, DAC_MID_CODE)
  endtask : t_boot
  task automatic t_run();
    drive(2'h2, 10'h155, 10'h2aa);
    wait_q();
    `CHK(link.i_valid, 1'b1)
    `CHK(link.i_data, 10'h355)
    `CHK(link.q_data, 10'h0aa)
    drive(2'h3, 10'h000, 10'h3ff);
    tick(6);
    `CHK(link.i_data, 10'h355)
    tick(1);
    `CHK(link.i_data, 10'h200)
    `CHK(link.q_data, 10'h0aa)
    tick(1);
    `CHK(link.q_data, 10'h1ff)
    `CHK(link.q_valid, 1'b1)
  endtask : t_run
  task automatic t_standby();
    drive(2'h1, 10'h100, 10'h100);
    tick(20);
    `CHK({irun, qrun}, 2'h2)
    `CHK(link.q_valid, 1'b0)
    `CHK(link.q_data, 10'h1ff)
    `CHK(link.i_data, 10'h300)
    drive(2'h2, 10'h100, 10'h100);
    wait_q();
    // Sync stages add to the twenty warm-up cycles.
    `CHK(k, DAC_RECOVER + 5)
  endtask : t_standby
  task automatic t_fifo();
    tick(20);
    `CHK(ovf, 1'b1)
    drive(2'h0, 10'h100, 10'h100);
    tick(20);
    `CHK(irun, 1'b0)
    @(posedge clk_in);
    wr <= 1'b1;
    #1;
    n = 0;
    repeat (12) begin
      if (wv === 1'b1) begin
        n++;
        `CHK({iw, qw}, {10'h355, 10'h0aa})
      end
      tick(1);
    end
    `CHK(n, 8)
  endtask : t_fifo
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_boot();
    t_run();
    t_standby();
    t_fifo();
    print_verdict();
  end
endmodule : dac_tb_top
`default_nettype wire
